// *** rtl/adcs_pkg.sv ***
package adcs_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register byte offsets on the 8-bit internal bus
	localparam logic [3:0] RES_A_HI_OFS     = 4'h0;
	localparam logic [3:0] RES_A_LO_OFS     = 4'h1;
	localparam logic [3:0] RES_B_HI_OFS     = 4'h2;
	localparam logic [3:0] RES_B_LO_OFS     = 4'h3;
	localparam logic [3:0] RES_C_HI_OFS     = 4'h4;
	localparam logic [3:0] RES_C_LO_OFS     = 4'h5;
	localparam logic [3:0] RES_D_HI_OFS     = 4'h6;
	localparam logic [3:0] RES_D_LO_OFS     = 4'h7;
	localparam logic [3:0] CTRL_STATUS_OFS  = 4'h8;
	localparam logic [3:0] TRIG_CTRL_OFS    = 4'h9;

	////////////////////////////////////////////////////////////////////////////
	// Field positions in conv_control_status
	localparam int END_FLAG_BIT      = 7;
	localparam int IRQ_ENABLE_BIT    = 6;
	localparam int START_BIT         = 5;
	localparam int SCAN_BIT          = 4;
	localparam int SPEED_BIT         = 3;
	localparam int GROUP_BIT         = 2;
	localparam int CHAN_HI_BIT       = 1;
	localparam int CHAN_LO_BIT       = 0;

	// Field position in trigger_control
	localparam int TRIG_ENABLE_BIT   = 7;

	////////////////////////////////////////////////////////////////////////////
	// Values after reset
	localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
	localparam logic [7:0] TRIG_CTRL_RESET   = 8'h7F;
	localparam logic [6:0] TRIG_CTRL_ONES    = 7'h7F;
	localparam logic [9:0] RESULT_RESET      = 10'h000;
	localparam logic [7:0] RDATA_RESET       = 8'h00;
	localparam logic [7:0] UNMAPPED_RDATA    = 8'h00;
	localparam logic [5:0] RESULT_PAD        = 6'h00;

	////////////////////////////////////////////////////////////////////////////
	// Conversion lengths in states, one state per sys_clk cycle
	localparam int CONV_FIRST_SLOW_STATES = 266;
	localparam int CONV_FIRST_FAST_STATES = 134;
	localparam int CONV_NEXT_SLOW_STATES  = 256;
	localparam int CONV_NEXT_FAST_STATES  = 128;
	localparam int CNT_W                  = 9;

	localparam logic [CNT_W-1:0] FIRST_SLOW_LAST = CNT_W'(CONV_FIRST_SLOW_STATES - 1);
	localparam logic [CNT_W-1:0] FIRST_FAST_LAST = CNT_W'(CONV_FIRST_FAST_STATES - 1);
	localparam logic [CNT_W-1:0] NEXT_SLOW_LAST  = CNT_W'(CONV_NEXT_SLOW_STATES - 1);
	localparam logic [CNT_W-1:0] NEXT_FAST_LAST  = CNT_W'(CONV_NEXT_FAST_STATES - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO        = 9'h000;
	localparam logic [CNT_W-1:0] CNT_ONE         = 9'h001;

	////////////////////////////////////////////////////////////////////////////
	// Sequencer states
	typedef enum logic {
		ADCS_IDLE,
		ADCS_CONVERT
	} adcs_state_t;

endpackage

// *** rtl/adcs_trig_sync.sv ***
module adcs_trig_sync (
	input  wire logic sys_clk,
	input  wire logic resetn,
	input  wire logic pin_in,
	output logic      fall_q
);

	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic level_q;

	////////////////////////////////////////////////////////////////////////////
	// Three stages; first stage only feeds the second
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Agreed level edge
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			level_q <= 1'b1;
			fall_q  <= 1'b0;
		end else begin
			fall_q <= 1'b0;
			if (s2_q == s3_q) begin
				level_q <= s2_q;
				fall_q  <= level_q && !s2_q;
			end
		end
	end

endmodule

// *** rtl/adcs_top.sv ***
// Notes on behaviour
// - Interrupt enable gates the end interrupt; flag set with enable raises it.
// - Writing start 0 stops; start resets to 0 and reads 1 while converting.
// - Single mode converts once, then clears start and goes idle.
// - Scan mode repeats while start stays 1; only software, reset or standby stop it.
// - Scan bit: 0 single mode (reset value), 1 scan mode.
// - Speed bit: 0 gives 266 states, 1 gives 134 states for a first conversion; 256 and 128 for later scan ones.
// - Single: three bits pick channel; scan: top bit group, low bits last channel.
// - A scan starts on the group's first channel, 0 or 4.
// - Scan moves to the next channel straight after each conversion.
// - Each result goes to the result register of its channel.
// - Single end: store, set flag, clear start in one step; interrupt one cycle later.
// - Scan end of group: set flag, interrupt, restart at first channel.
// - Flag clears only after a read of the status then a write of 0, or on reset or standby.
// - One write may set start and change settings; new settings are used.
// - Restarting a halted scan begins at the group's first channel.
// - With trigger enable 1 a falling pin edge sets start; else pin ignored.
// - Trigger control bits 6 to 0 are read-only and read as 1.
// - Reset and standby set trigger control to 7F.
// - Reading a high byte returns it and copies the low byte to the latch.
// - Reading a low byte returns the latch, not the live byte.
// - Inputs 0/4 to A, 1/5 to B, 2/6 to C, 3/7 to D.
// - Results are left-justified 10 bits; bits 5 to 0 read 0.
// - Writing 0 clears the flag only if it was read as 1 before.
// - Reset and standby clear every result register to 0000.
module adcs_top
	import adcs_pkg::*;
#(
	parameter int NUM_RESULTS = 4,
	parameter int RESULT_W    = 10
) (
	input  wire logic                sys_clk,
	input  wire logic                resetn,
	input  wire logic                standby,
	input  wire logic [3:0]          bus_addr,
	input  wire logic [7:0]          bus_wdata,
	input  wire logic                bus_rd,
	input  wire logic                bus_wr,
	output logic      [7:0]          bus_rdata_q,
	input  wire logic                ext_trigger_pin,
	input  wire logic [RESULT_W-1:0] conv_result_in,
	output logic      [2:0]          mux_chan_q,
	output logic                     conv_busy_q,
	output logic                     end_irq_request_q
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic                conv_end_flag_q;
	logic                end_irq_enable_q;
	logic                conv_start_bit_q;
	logic                scan_mode_q;
	logic                conv_speed_select_q;
	logic [2:0]          chan_select_q;
	logic                ext_trigger_enable_q;
	logic                flag_armed_q;
	logic [7:0]          temp_latch_q;
	logic [RESULT_W-1:0] result_q [NUM_RESULTS];

	adcs_state_t         state_q;
	logic [CNT_W-1:0]    cnt_q;
	logic                first_q;

	logic                trig_fall;
	logic                csr_wr;
	logic                csr_rd;
	logic                trig_wr;
	logic                flag_clear;
	logic                trig_start;
	logic [CNT_W-1:0]    cnt_last;
	logic                conv_done;
	logic                group_last;
	logic                flag_set;
	logic                single_end;
	logic [1:0]          read_index;
	logic [2:0]          group_first;

	////////////////////////////////////////////////////////////////////////////
	// External trigger
	adcs_trig_sync u_trig_sync (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.pin_in  (ext_trigger_pin),
		.fall_q  (trig_fall)
	);

	assign trig_start = trig_fall && ext_trigger_enable_q;

	////////////////////////////////////////////////////////////////////////////
	// Bus decode
	assign csr_wr     = bus_wr && (bus_addr == CTRL_STATUS_OFS);
	assign csr_rd     = bus_rd && (bus_addr == CTRL_STATUS_OFS);
	assign trig_wr    = bus_wr && (bus_addr == TRIG_CTRL_OFS);
	assign read_index = bus_addr[2:1];

	assign flag_clear = csr_wr && !bus_wdata[END_FLAG_BIT] && flag_armed_q;

	////////////////////////////////////////////////////////////////////////////
	// Conversion timing
	// Terminal count by speed
	always_comb begin
		cnt_last = FIRST_SLOW_LAST;
		if (first_q) begin
			cnt_last = conv_speed_select_q ? FIRST_FAST_LAST : FIRST_SLOW_LAST;
		end else begin
			cnt_last = conv_speed_select_q ? NEXT_FAST_LAST : NEXT_SLOW_LAST;
		end
	end

	// No completion once start is gone
	assign conv_done   = (state_q == ADCS_CONVERT) && conv_start_bit_q && (cnt_q == cnt_last);
	// Low bits mark the last scanned channel
	assign group_last  = !scan_mode_q || (mux_chan_q[1:0] == chan_select_q[1:0]);
	assign flag_set    = conv_done && group_last;
	assign single_end  = conv_done && !scan_mode_q;
	assign group_first = {chan_select_q[GROUP_BIT], 2'b00};

	////////////////////////////////////////////////////////////////////////////
	// Control and status register
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			end_irq_enable_q    <= CTRL_STATUS_RESET[IRQ_ENABLE_BIT];
			scan_mode_q         <= CTRL_STATUS_RESET[SCAN_BIT];
			conv_speed_select_q <= CTRL_STATUS_RESET[SPEED_BIT];
			chan_select_q       <= CTRL_STATUS_RESET[2:0];
		end else if (standby) begin
			end_irq_enable_q    <= CTRL_STATUS_RESET[IRQ_ENABLE_BIT];
			scan_mode_q         <= CTRL_STATUS_RESET[SCAN_BIT];
			conv_speed_select_q <= CTRL_STATUS_RESET[SPEED_BIT];
			chan_select_q       <= CTRL_STATUS_RESET[2:0];
		end else if (csr_wr) begin
			end_irq_enable_q    <= bus_wdata[IRQ_ENABLE_BIT];
			scan_mode_q         <= bus_wdata[SCAN_BIT];
			conv_speed_select_q <= bus_wdata[SPEED_BIT];
			chan_select_q       <= bus_wdata[2:0];
		end
	end

	// Start bit: hardware clear, then software, then trigger; the set wins
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			conv_start_bit_q <= CTRL_STATUS_RESET[START_BIT];
		end else if (standby) begin
			conv_start_bit_q <= CTRL_STATUS_RESET[START_BIT];
		end else begin
			if (single_end) begin
				conv_start_bit_q <= 1'b0;
			end
			if (csr_wr) begin
				conv_start_bit_q <= bus_wdata[START_BIT];
			end
			if (trig_start) begin
				conv_start_bit_q <= 1'b1;
			end
		end
	end

	// End flag and its read arming
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			conv_end_flag_q <= CTRL_STATUS_RESET[END_FLAG_BIT];
			flag_armed_q    <= 1'b0;
		end else if (standby) begin
			conv_end_flag_q <= CTRL_STATUS_RESET[END_FLAG_BIT];
			flag_armed_q    <= 1'b0;
		end else begin
			// Arm only on a read of 1
			if (csr_rd && conv_end_flag_q) begin
				flag_armed_q <= 1'b1;
			end
			if (flag_clear) begin
				conv_end_flag_q <= 1'b0;
				flag_armed_q    <= 1'b0;
			end
			if (flag_set) begin
				conv_end_flag_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Trigger control register
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ext_trigger_enable_q <= TRIG_CTRL_RESET[TRIG_ENABLE_BIT];
		end else if (standby) begin
			ext_trigger_enable_q <= TRIG_CTRL_RESET[TRIG_ENABLE_BIT];
		end else if (trig_wr) begin
			ext_trigger_enable_q <= bus_wdata[TRIG_ENABLE_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_q    <= ADCS_IDLE;
			cnt_q      <= CNT_ZERO;
			first_q    <= 1'b1;
			mux_chan_q <= CTRL_STATUS_RESET[2:0];
		end else if (standby) begin
			state_q    <= ADCS_IDLE;
			cnt_q      <= CNT_ZERO;
			first_q    <= 1'b1;
			mux_chan_q <= CTRL_STATUS_RESET[2:0];
		end else begin
			case (state_q)
				ADCS_IDLE: begin
					cnt_q   <= CNT_ZERO;
					first_q <= 1'b1;
					if (conv_start_bit_q) begin
						state_q <= ADCS_CONVERT;
						mux_chan_q <= scan_mode_q ? group_first : chan_select_q;
					end
				end
				ADCS_CONVERT: begin
					if (!conv_start_bit_q) begin
						state_q <= ADCS_IDLE;
						cnt_q   <= CNT_ZERO;
					end else if (conv_done) begin
						cnt_q <= CNT_ZERO;
						if (!scan_mode_q) begin
							state_q <= ADCS_IDLE;
						end else begin
							first_q    <= 1'b0;
							mux_chan_q <= group_last ? group_first : mux_chan_q + 3'd1;
						end
					end else begin
						cnt_q <= cnt_q + CNT_ONE;
					end
				end
				default: begin
					state_q <= ADCS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			conv_busy_q <= 1'b0;
		end else begin
			conv_busy_q <= (state_q == ADCS_CONVERT) && conv_start_bit_q && !single_end
				&& !standby;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Result registers
	for (genvar i = 0; i < NUM_RESULTS; i++) begin : g_result
		always_ff @(posedge sys_clk or negedge resetn) begin
			if (!resetn) begin
				result_q[i] <= RESULT_RESET;
			end else if (standby) begin
				result_q[i] <= RESULT_RESET;
			end else if (conv_done && (mux_chan_q[1:0] == 2'(i))) begin
				result_q[i] <= conv_result_in;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read path
	// High read loads the latch
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			temp_latch_q <= RDATA_RESET;
		end else if (bus_rd && !bus_addr[3] && !bus_addr[0]) begin
			temp_latch_q <= {result_q[read_index][1:0], RESULT_PAD};
		end
	end

	// Data held until the next read
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			bus_rdata_q <= RDATA_RESET;
		end else if (bus_rd) begin
			if (!bus_addr[3]) begin
				if (!bus_addr[0]) begin
					bus_rdata_q <= result_q[read_index][9:2];
				end else begin
					bus_rdata_q <= temp_latch_q;
				end
			end else if (bus_addr == CTRL_STATUS_OFS) begin
				bus_rdata_q <= {conv_end_flag_q, end_irq_enable_q, conv_start_bit_q,
					scan_mode_q, conv_speed_select_q, chan_select_q};
			end else if (bus_addr == TRIG_CTRL_OFS) begin
				bus_rdata_q <= {ext_trigger_enable_q, TRIG_CTRL_ONES};
			end else begin
				bus_rdata_q <= UNMAPPED_RDATA;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt request, one cycle behind the flag
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			end_irq_request_q <= 1'b0;
		end else begin
			end_irq_request_q <= conv_end_flag_q && end_irq_enable_q;
		end
	end

endmodule

// *** bench/adcs_analog_model.sv ***
module adcs_analog_model (
	input  wire logic [2:0] mux_chan_q,
	input  wire logic [6:0] bias,
	output logic      [9:0] conv_result_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// Channel in top bits, so a misrouted store shows
	assign conv_result_in = {mux_chan_q, bias};
endmodule

// *** bench/adcs_chk.sv ***
module adcs_chk
	import adcs_pkg::*;
#(
	parameter int RESULT_W = 10
) (
	input wire logic                sys_clk,
	input wire logic                resetn,
	input wire logic                standby,
	input wire logic [3:0]          bus_addr,
	input wire logic [7:0]          bus_wdata,
	input wire logic                bus_rd,
	input wire logic                bus_wr,
	input wire logic [7:0]          bus_rdata_q,
	input wire logic                ext_trigger_pin,
	input wire logic [RESULT_W-1:0] conv_result_in,
	input wire logic [2:0]          mux_chan_q,
	input wire logic                conv_busy_q,
	input wire logic                end_irq_request_q
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn || standby);

	sequence s_csr_rd;
		bus_rd && bus_addr == CTRL_STATUS_OFS;
	endsequence
	sequence s_start_wr;
		bus_wr && bus_addr == CTRL_STATUS_OFS && bus_wdata[START_BIT] && !conv_busy_q;
	endsequence
	// Pin held high, so no trigger can race the stop
	sequence s_stop_wr;
		ext_trigger_pin [*5] ##0 (bus_wr && bus_addr == CTRL_STATUS_OFS && !bus_wdata[START_BIT]);
	endsequence

	////////////////////////////////////////////////////////////////////////////
	chk_trig_ones: assert property (
		bus_rd && bus_addr == TRIG_CTRL_OFS |=> bus_rdata_q[6:0] == TRIG_CTRL_ONES)
		else $error("trigger control low bits not ones");
	chk_low_pad: assert property (
		bus_rd && bus_addr < CTRL_STATUS_OFS && bus_addr[0] |=> bus_rdata_q[5:0] == RESULT_PAD)
		else $error("result low byte pad not zero");
	chk_irq_gate: assert property (
		s_csr_rd |=> end_irq_request_q == (bus_rdata_q[END_FLAG_BIT] & bus_rdata_q[IRQ_ENABLE_BIT]))
		else $error("interrupt differs from flag and enable");
	chk_start_busy: assert property (
		s_csr_rd ##0 conv_busy_q ##1 conv_busy_q |-> bus_rdata_q[START_BIT])
		else $error("start bit low while converting");
	chk_start_runs: assert property (
		s_start_wr |-> ##[1:3] conv_busy_q)
		else $error("start write did not begin conversion");
	chk_stop_halts: assert property (
		s_stop_wr |-> ##[1:3] !conv_busy_q)
		else $error("stop write did not halt conversion");
	chk_rdata_hold: assert property (
		!bus_rd |=> $stable(bus_rdata_q))
		else $error("read data changed without a read");
	chk_scan_group: assert property (
		conv_busy_q && $past(conv_busy_q) && $changed(mux_chan_q)
		|-> mux_chan_q[2] == $past(mux_chan_q[2]))
		else $error("group changed inside a scan");
endmodule

// *** bench/tb_top.sv ***
module tb_top
	import adcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic       sys_clk = 0, resetn = 0, standby = 0, bus_rd = 0, bus_wr = 0;
	logic       ext_trigger_pin = 1, conv_busy_q, end_irq_request_q;
	logic [3:0] bus_addr = 0;
	logic [7:0] bus_wdata = 0, bus_rdata_q, rd_q, cfg;
	logic [6:0] bias = 7'h2A;
	logic [9:0] conv_result_in;
	logic [2:0] mux_chan_q, ch;
	int         fail_count = 0, n_checks = 0, n, lo;
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("Error %0t: got %h expected %h", $time, g, e); end end

	always #5 sys_clk = ~sys_clk;

	adcs_top i_dut (.sys_clk(sys_clk), .resetn(resetn), .standby(standby),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rd(bus_rd), .bus_wr(bus_wr),
		.bus_rdata_q(bus_rdata_q), .ext_trigger_pin(ext_trigger_pin),
		.conv_result_in(conv_result_in), .mux_chan_q(mux_chan_q),
		.conv_busy_q(conv_busy_q), .end_irq_request_q(end_irq_request_q));
	adcs_analog_model i_model (.mux_chan_q(mux_chan_q), .bias(bias),
		.conv_result_in(conv_result_in));

	////////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk) #1;
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1;
		@(posedge sys_clk) #1;
		bus_wr = 0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge sys_clk) #1;
		bus_addr = a;
		bus_rd = 1;
		@(posedge sys_clk) #1;
		bus_rd = 0;
		rd_q = bus_rdata_q;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		rd(a);
		`CHK(rd_q, e)
	endtask
	// Polling bounded; each poll is two cycles
	task automatic wait_flag(input int lim);
		for (int i = 0; i < lim; i++) begin
			rd(CTRL_STATUS_OFS);
			if (rd_q[END_FLAG_BIT] === 1'b1)
				return;
		end
		fail_count++;
		$display("Error %0t: end flag never set", $time);
	endtask
	task automatic chk_res(input logic [2:0] c, input logic [6:0] b);
		rchk({1'b0, c[1:0], 1'b0}, {c, b[6:2]});
		rchk({1'b0, c[1:0], 1'b1}, {b[1:0], 6'h00});
	endtask
	task automatic finish_test();
		$display("Checks %0d, errors %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		#200us;
		fail_count++;
		$display("Error %0t: watchdog expired", $time);
		finish_test();
	end

	initial begin
		repeat (12) @(posedge sys_clk);
		#1 resetn = 1;
		rchk(CTRL_STATUS_OFS, CTRL_STATUS_RESET);
		rchk(TRIG_CTRL_OFS, 8'h7F);
		rchk(4'hA, UNMAPPED_RDATA);
		for (int r = 0; r < 8; r++) rchk(4'(r), 8'h00);
		wr(TRIG_CTRL_OFS, 8'h00);
		rchk(TRIG_CTRL_OFS, 8'h7F);
		wr(TRIG_CTRL_OFS, 8'h80);
		rchk(TRIG_CTRL_OFS, 8'hFF);
		@(posedge sys_clk) #1 standby = 1;
		@(posedge sys_clk) #1 standby = 0;
		rchk(TRIG_CTRL_OFS, 8'h7F);
		// Single mode, both speeds
		for (int s = 0; s < 2; s++) begin
			ch = 3'(5 + 2 * s);
			cfg = {2'b01, 1'b1, 1'b0, 1'(s), ch};
			lo = s ? CONV_FIRST_FAST_STATES : CONV_FIRST_SLOW_STATES;
			wr(CTRL_STATUS_OFS, cfg);
			// Look just after the edge, once the request has settled
			for (n = 0; n < 400 && end_irq_request_q !== 1'b1; n++) @(posedge sys_clk) #1;
			`CHK(n >= lo - 4 && n <= lo + 8, 1'b1)
			wr(CTRL_STATUS_OFS, {2'b01, 1'b0, 1'b0, 1'(s), ch});
			rchk(CTRL_STATUS_OFS, {2'b11, 1'b0, 1'b0, 1'(s), ch});
			`CHK(end_irq_request_q, 1'b1)
			wr(CTRL_STATUS_OFS, {2'b01, 1'b0, 1'b0, 1'(s), ch});
			rchk(CTRL_STATUS_OFS, {2'b01, 1'b0, 1'b0, 1'(s), ch});
			chk_res(ch, bias);
		end
		// Slow scan of inputs 0 and 1, interrupt on; second channel follows with no gap
		bias = 7'h4C;
		wr(CTRL_STATUS_OFS, 8'h71);
		lo = CONV_FIRST_SLOW_STATES + CONV_NEXT_SLOW_STATES;
		for (n = 0; n < 900 && end_irq_request_q !== 1'b1; n++) @(posedge sys_clk) #1;
		`CHK(n >= lo - 4 && n <= lo + 8, 1'b1)
		`CHK(mux_chan_q, 3'h0)
		rchk(CTRL_STATUS_OFS, 8'hF1);
		wr(CTRL_STATUS_OFS, 8'h11);
		chk_res(3'd0, bias);
		chk_res(3'd1, bias);
		// Scan over inputs 4 to 6, interrupt off
		bias = 7'h15;
		wr(CTRL_STATUS_OFS, 8'h3E);
		wait_flag(300);
		`CHK(rd_q[START_BIT], 1'b1)
		`CHK(end_irq_request_q, 1'b0)
		wr(CTRL_STATUS_OFS, 8'h1E);
		for (int c = 4; c < 7; c++) chk_res(3'(c), bias);
		// Restart on other group, then abort
		bias = 7'h33;
		wr(CTRL_STATUS_OFS, 8'h38);
		repeat (20) @(posedge sys_clk);
		`CHK(mux_chan_q, 3'h0)
		wr(CTRL_STATUS_OFS, 8'h18);
		repeat (4) @(posedge sys_clk);
		`CHK(conv_busy_q, 1'b0)
		chk_res(3'd4, 7'h15);
		// External trigger, enabled then ignored
		wr(TRIG_CTRL_OFS, 8'h80);
		wr(CTRL_STATUS_OFS, 8'h0B);
		@(posedge sys_clk) #1 ext_trigger_pin = 0;
		wait_flag(100);
		chk_res(3'd3, bias);
		ext_trigger_pin = 1;
		wr(TRIG_CTRL_OFS, 8'h00);
		wr(CTRL_STATUS_OFS, 8'h0B);
		@(posedge sys_clk) #1 ext_trigger_pin = 0;
		repeat (10) @(posedge sys_clk);
		rchk(CTRL_STATUS_OFS, 8'h0B);
		finish_test();
	end
endmodule

bind adcs_top adcs_chk #(.RESULT_W(RESULT_W)) i_chk (.sys_clk(sys_clk), .resetn(resetn),
	.standby(standby), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rd(bus_rd),
	.bus_wr(bus_wr), .bus_rdata_q(bus_rdata_q), .ext_trigger_pin(ext_trigger_pin),
	.conv_result_in(conv_result_in), .mux_chan_q(mux_chan_q), .conv_busy_q(conv_busy_q),
	.end_irq_request_q(end_irq_request_q));
